/* File: include/crps_pkg.sv */
// Package with shared types and constants for the reset / power-good control
package crps_pkg;

  // Bus clock rate in hertz
  localparam int unsigned CLK_HZ = 10_000_000;

  // Stored-state width and configuration-strap width
  localparam int unsigned CFG_W = 16;
  localparam int unsigned STATE_W = 16;

  // Last wait count before handler start (three cycles after acknowledge issue), and latency to release
  localparam logic [3:0] ACK_TO_RUN = 4'h2;
  localparam logic [1:0] BUS_RELEASE_CLKS = 2'h2;

  // Default stored execution state after reset
  localparam logic [15:0] STATE_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0000;

  // Cache invalidate walk: number of lines
  localparam int unsigned LINES = 16;
  localparam int unsigned LINE_AW = 4;

  // Operating state of the core
  typedef enum logic [2:0] {
    CRPS_RESET,
    CRPS_RUN,
    CRPS_SAVE,
    CRPS_ACK,
    CRPS_MGMT_RUN,
    CRPS_FLOAT
  } crps_mode_t;

  // Bundled status returned to the user side
  typedef struct packed {
    logic in_reset;
    logic sys_mgmt_state;
    logic ack_txn;
    logic handler_run;
    logic cache_clean;
  } crps_stat_t;

endpackage

/* File: rtl/crps_ctrl.sv */
// Reset, power-good and system-management entry control of the processor
`timescale 1ns/1ps
`default_nettype none
module crps_ctrl (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic power_ok_in_i,
  input wire logic bus_reset_n_i,
  input wire logic sys_mgmt_irq_n_i,
  input wire logic [15:0] cfg_pins_i,
  input wire logic [15:0] exec_state_i,
  input wire logic bus_drive_req_i,
  output logic bus_oe_o,
  output logic outputs_float_o,
  output logic [15:0] cfg_latched_o,
  output logic [15:0] saved_state_o,
  output logic [3:0] inval_line_o,
  output crps_pkg::crps_stat_t stat_o
);
  logic pok_s;
  logic irq_n_s;
  logic rst_act;
  logic rst_act_q;
  logic [3:0] wait_q;
  logic [3:0] line_q;
  logic clean_q;
  crps_pkg::crps_mode_t mode_q;
  crps_pkg::crps_mode_t mode_d;

  crps_sync2 #(.RST_VAL(1'b0)) u_sync_pok (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(power_ok_in_i),
    .q_o(pok_s)
  );

  crps_sync2 #(.RST_VAL(1'b1)) u_sync_irq (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(sys_mgmt_irq_n_i),
    .q_o(irq_n_s)
  );

  // Reset counts as active while power-good is low as well
  assign rst_act = ~bus_reset_n_i | ~pok_s;

  // Registered reset, used to find the start of each reset
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      rst_act_q <= 1'b1;
    else
      rst_act_q <= rst_act;
  end

  // Next operating state
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      crps_pkg::CRPS_RESET:
      begin
        if (!rst_act && !irq_n_s)
          mode_d = crps_pkg::CRPS_FLOAT;
        else if (!rst_act)
          mode_d = crps_pkg::CRPS_RUN;
      end
      crps_pkg::CRPS_RUN:
      begin
        if (!irq_n_s)
          mode_d = crps_pkg::CRPS_SAVE;
      end
      crps_pkg::CRPS_SAVE:
        mode_d = crps_pkg::CRPS_ACK;
      crps_pkg::CRPS_ACK:
      begin
        if (wait_q == crps_pkg::ACK_TO_RUN)
          mode_d = crps_pkg::CRPS_MGMT_RUN;
      end
      crps_pkg::CRPS_MGMT_RUN:
        mode_d = crps_pkg::CRPS_MGMT_RUN;
      crps_pkg::CRPS_FLOAT:
        mode_d = crps_pkg::CRPS_FLOAT;
      default:
        mode_d = crps_pkg::CRPS_RESET;
    endcase
    if (rst_act)
      mode_d = crps_pkg::CRPS_RESET;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      mode_q <= crps_pkg::CRPS_RESET;
    else
      mode_q <= mode_d;
  end

  // Wait counter between acknowledge and handler start
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || mode_q != crps_pkg::CRPS_ACK)
      wait_q <= 4'h0;
    else
      wait_q <= wait_q + 4'h1;
  end

  // cache invalidate walk
  // Lines are dropped, never written back, so no bus traffic is needed
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || (rst_act && !rst_act_q))
    begin
      line_q <= 4'h0;
      clean_q <= 1'b0;
    end
    else if (rst_act && !clean_q)
    begin
      line_q <= line_q + 4'h1;
      clean_q <= (line_q == 4'(crps_pkg::LINES - 1));
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      cfg_latched_o <= crps_pkg::CFG_RST;
    else if (mode_q == crps_pkg::CRPS_RESET && !rst_act)
      cfg_latched_o <= cfg_pins_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || rst_act)
      saved_state_o <= crps_pkg::STATE_RST;
    else if (mode_q == crps_pkg::CRPS_SAVE)
      saved_state_o <= exec_state_i;
  end

  // release bus outputs
  // Reset as seen by the unsynchronised path drops drive one clock later
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      bus_oe_o <= 1'b0;
    else
      bus_oe_o <= bus_drive_req_i && !rst_act && mode_d != crps_pkg::CRPS_FLOAT
                  && mode_d != crps_pkg::CRPS_RESET;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      outputs_float_o <= 1'b0;
      inval_line_o <= 4'h0;
      stat_o <= '0;
    end
    else
    begin
      outputs_float_o <= (mode_d == crps_pkg::CRPS_FLOAT);
      inval_line_o <= line_q;
      stat_o.in_reset <= rst_act;
      stat_o.sys_mgmt_state <= mode_d == crps_pkg::CRPS_ACK
                               || mode_d == crps_pkg::CRPS_MGMT_RUN;
      stat_o.ack_txn <= mode_q == crps_pkg::CRPS_SAVE && !rst_act;
      stat_o.handler_run <= (mode_d == crps_pkg::CRPS_MGMT_RUN);
      stat_o.cache_clean <= clean_q;
    end
  end

  chk_bus_release: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !bus_reset_n_i |-> ##[1:2] !bus_oe_o)
    else $error("bus drive held after reset");
  // Acknowledge seen with the core out of reset
  sequence seq_ack_entry;
    stat_o.ack_txn && !rst_act;
  endsequence
  // Two further cycles with reset inactive
  sequence seq_no_reset2;
    !rst_act ##1 !rst_act;
  endsequence
  chk_ack_handler: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(stat_o.ack_txn) && !rst_act
    |-> ##[1:5] (stat_o.handler_run || rst_act))
    else $error("handler did not follow ack");
  chk_handler_start: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i)
    seq_ack_entry ##1 seq_no_reset2 |=> stat_o.handler_run)
    else $error("handler start late");
  chk_ack_single: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    stat_o.ack_txn |=> !stat_o.ack_txn)
    else $error("acknowledge longer than one cycle");
  chk_float_rel: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_q == crps_pkg::CRPS_RESET && !rst_act && !irq_n_s |=> outputs_float_o)
    else $error("outputs not floated");
  chk_cfg_capture: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_q == crps_pkg::CRPS_RESET && !rst_act
    |=> cfg_latched_o == $past(cfg_pins_i))
    else $error("config not captured");
  chk_state_save: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_q == crps_pkg::CRPS_SAVE && !rst_act
    |=> saved_state_o == $past(exec_state_i))
    else $error("state not saved");
endmodule
`default_nettype wire

/* File: rtl/crps_sync2.sv */
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module crps_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: verification/crps_board_model.sv */
// Board-side power-good and reset sequencer model
`timescale 1ns/1ps
`default_nettype none
module crps_board_model #(
  parameter int RST_CYC = 10000
) (
  input wire logic mclk_i,
  input wire logic pwr_req_i,
  input wire logic rst_req_i,
  output logic power_ok_o,
  output logic bus_reset_n_o
);
  // clean low start, rise after settling, drop at any time
  // One process owns power-good so it has a single driver
  initial
  begin
    power_ok_o = 1'b0;
    forever
    begin
      @(posedge pwr_req_i);
      repeat (4) @(posedge mclk_i);
      #1 power_ok_o = 1'b1;
      @(negedge pwr_req_i);
      power_ok_o = 1'b0;
    end
  end
  // settle, then one reset pulse, power-good kept high
  initial
  begin
    bus_reset_n_o = 1'b0;
    forever
    begin
      @(posedge pwr_req_i or posedge rst_req_i);
      bus_reset_n_o = 1'b0;
      repeat (4) @(posedge mclk_i);
      repeat (RST_CYC) @(posedge mclk_i);
      #1 bus_reset_n_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/crps_ctrl_tb_top.sv */
// Self-checking bench for reset and management entry control
`timescale 1ns/1ps
`default_nettype none
module crps_ctrl_tb_top;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, pwr_req = 1'b0, rst_req = 1'b0;
  logic power_ok, bus_reset_n, irq_n = 1'b1, drive_req = 1'b0, bus_oe, flt;
  logic [3:0] inval;
  logic [15:0] cfg = 16'h0000, exec_st = 16'h0000, cfg_q, st_q;
  crps_pkg::crps_stat_t stat;
  int miscompares = 0, check_count = 0, cyc = 0, n;
  // 10 MHz bus clock
  always #50 mclk_i = ~mclk_i;
  // One millisecond reset pulses keep the run near 20k cycles
  crps_board_model #(.RST_CYC(10000)) crps_board_model_i (
    .mclk_i(mclk_i), .pwr_req_i(pwr_req), .rst_req_i(rst_req),
    .power_ok_o(power_ok), .bus_reset_n_o(bus_reset_n));
  crps_ctrl crps_ctrl_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .power_ok_in_i(power_ok), .bus_reset_n_i(bus_reset_n),
    .sys_mgmt_irq_n_i(irq_n), .cfg_pins_i(cfg), .exec_state_i(exec_st),
    .bus_drive_req_i(drive_req), .bus_oe_o(bus_oe), .outputs_float_o(flt),
    .cfg_latched_o(cfg_q), .saved_state_o(st_q), .inval_line_o(inval),
    .stat_o(stat));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Step past edges; drives and samples land 1 ns later
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  // Bounded wait for the board to release reset; looked at on the edge
  // itself, so the board's drive just after the edge cannot race it
  task automatic wait_rel();
    n = 0;
    while (bus_reset_n !== 1'b1 && n < 12000)
    begin
      @(posedge mclk_i);
      n++;
    end
    #1;
    if (n >= 12000)
    begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic power_on();
    cfg = 16'ha5c3;
    pwr_req = 1'b1;
    tick(20);
    chk(stat.in_reset, 1'b1);
    chk(bus_oe, 1'b0);
    wait_rel();
    chk(stat.cache_clean, 1'b1);
    drive_req = 1'b1;
    tick(3);
    chk(cfg_q, 16'ha5c3);
    chk(bus_oe, 1'b1);
    cfg = 16'h0000;
    tick(2);
    chk(cfg_q, 16'ha5c3);
  endtask
  task automatic mgmt_entry();
    exec_st = 16'h1234;
    irq_n = 1'b0;
    n = 0;
    while (stat.ack_txn !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'h0004);
    chk(stat.sys_mgmt_state, 1'b1);
    chk(st_q, 16'h1234);
    chk(stat.handler_run, 1'b0);
    exec_st = 16'h0000;
    irq_n = 1'b1;
    tick(1);
    chk(stat.ack_txn, 1'b0);
    tick(2);
    chk(stat.handler_run, 1'b1);
  endtask
  task automatic warm_float();
    rst_req = 1'b1;
    tick(2);
    chk(bus_oe, 1'b0);
    tick(3);
    chk({12'h000, inval}, 16'h0003);
    irq_n = 1'b0;
    cfg = 16'h3c5a;
    wait_rel();
    tick(4);
    chk(flt, 1'b1);
    chk(bus_oe, 1'b0);
    chk(cfg_q, 16'h3c5a);
    irq_n = 1'b1;
    rst_req = 1'b0;
    tick(4);
    chk(flt, 1'b1);
    sys_rst_i = 1'b1;
    tick(3);
    sys_rst_i = 1'b0;
    tick(3);
    chk(flt, 1'b0);
  endtask
  task automatic power_drop();
    pwr_req = 1'b0;
    tick(1);
    chk(stat.in_reset, 1'b0);
    tick(4);
    chk(stat.in_reset, 1'b1);
    chk(bus_oe, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    tick(3);
    power_on();
    mgmt_entry();
    warm_float();
    power_drop();
    complete_run();
  end
endmodule
`default_nettype wire
